// *** core/rac_pkg.sv ***
// Shared constants, command codes and helpers for the ring adapter attachment.
// Assumes both ends run on one clock, ref_clk, with a synchronous reset.
package rac_pkg;

  // --------------------------------------------------------------------------
  // Sizes
  // --------------------------------------------------------------------------
  localparam int RAC_NPOS = 4;
  localparam int RAC_DW = 16;
  localparam int RAC_AW = 8;

  // --------------------------------------------------------------------------
  // Commands from the central control unit or maintenance processor
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    RAC_CMD_CONNECT, RAC_CMD_DISCONNECT, RAC_CMD_MASK, RAC_CMD_UNMASK,
    RAC_CMD_PROG_RESET, RAC_CMD_GCC, RAC_CMD_GET_L1, RAC_CMD_GET_L2,
    RAC_CMD_SET_ROUTE, RAC_CMD_READ_REG, RAC_CMD_MM_ADDR, RAC_CMD_MM_WRITE,
    RAC_CMD_MM_WRITE_INC, RAC_CMD_MM_READ, RAC_CMD_MM_READ_INC
  } rac_cmd_t;

  // --------------------------------------------------------------------------
  // Status field positions and reset values
  // --------------------------------------------------------------------------
  localparam int RAC_L1_DISC_BIT = 0;
  localparam int RAC_L1_PIOD_BIT = 1;
  localparam int RAC_L1_RESET_BIT = 2;
  localparam logic [1:0] RAC_L1_RESET_VAL = 2'h3;
  localparam int RAC_L2_PAR_B0 = 0;
  localparam int RAC_L2_PAR_B1 = 1;
  localparam int RAC_L2_PAR_BOTH = 2;
  localparam int RAC_L2_DMA_ERR = 3;
  localparam int RAC_GCC_DIRECT = 0;
  localparam int RAC_GCC_MAINT_STAT = 1;
  localparam int RAC_GCC_DISC_DONE = 2;
  localparam int RAC_GCC_PARITY = 3;
  localparam int RAC_GCC_MASK_ON = 4;
  localparam int RAC_GCC_LID_LSB = 8;
  localparam logic [7:0] RAC_REG_ADAPTER_LEVEL1_FLAG_ADDR = 8'h7E;
  localparam logic [7:0] RAC_LID_TYPEB_BASE = 8'h20;

  // --------------------------------------------------------------------------
  // Adapter storage map and timing counts
  // --------------------------------------------------------------------------
  localparam logic [2:0] RAC_SELFTEST_IDX = 3'h0;
  localparam logic [2:0] RAC_IRQREG_IDX = 3'h1;
  localparam logic [2:0] RAC_SSB_IDX = 3'h2;
  localparam logic [15:0] RAC_SELFTEST_PASS = 16'h00FF;
  localparam logic [15:0] RAC_LOBE_PASS = 16'h0F0F;
  localparam int RAC_SELFTEST_CYC = 16;
  localparam int RAC_LOBE_CYC = 32;

  // Odd parity over one byte.
  function automatic logic rac_par(input logic [7:0] b);
    return ~(^b);
  endfunction

endpackage

// *** core/rac_link_if.sv ***
// Adapter bus between the attachment logic and one ring adapter.
// Assumes both parties share ref_clk; no clock travels on this bundle.
`timescale 1ns/10ps
interface rac_link_if;
  import rac_pkg::*;
  logic [RAC_NPOS-1:0] grant;
  logic [RAC_NPOS-1:0] bus_err;
  logic mm_req;
  logic mm_wr;
  logic [1:0] mm_sel;
  logic [RAC_AW-1:0] mm_addr;
  logic [RAC_DW-1:0] mm_wdata;
  logic [1:0] mm_wpar;
  logic [RAC_NPOS-1:0] bus_req;
  logic [RAC_NPOS-1:0] irq_req;
  logic xfer_last;
  logic rd_valid;
  logic [RAC_DW-1:0] rd_data;
  logic [1:0] rd_par;

  modport dev (
    output grant, bus_err, mm_req, mm_wr, mm_sel, mm_addr, mm_wdata, mm_wpar,
    input bus_req, irq_req, xfer_last, rd_valid, rd_data, rd_par
  );
  modport adp (
    input grant, bus_err, mm_req, mm_wr, mm_sel, mm_addr, mm_wdata, mm_wpar,
    output bus_req, irq_req, xfer_last, rd_valid, rd_data, rd_par
  );
endinterface

// *** core/rac_attach_logic.sv ***
// Attachment logic between four ring adapter positions and the control side.
// Assumes commands arrive as one-cycle strobes on ref_clk and the adapter
// bus is driven by logic on the same clock, so no input is synchronised.
// How it works
// - Scan wheel grants pending bus requests in order.
// - Build parity error interrupts maintenance, reports id.
// - Connect clears disconnect and progio disable flags.
// - Routed positions interrupt maintenance, also when connected.
// - Mask suppresses maintenance interrupts despite pending requests.
// - Disconnect raises completion interrupt, ignoring the mask.
// - Masked and disconnected: no interrupts after completion except level4.
// - Unmask lets later adapter interrupts through again.
// - Programmed reset clears mask, sets readable reset flag.
// - Completion response shows whether masking is active.
// - Stop sets level1 flag at 7E; get-level1 clears.
// - Checker two logs adapter parity, raises level4.
// - Parity error sets completion bits and type B id.
// - Parity reported for byte0, byte1, both bytes.
// - Adapter in parity test drives parity zero.
// - Adapter self tests at reset, posts result.
// - Command block request interrupts once block free.
// - Wrap open runs lobe test, posts status.
// - Autoincrement access advances address after each transfer.
// - Transfer error signals bus error for retry.
// - Transfer error withholds adapter interrupt until level2 read.
// - Completion command clears maintenance error status.
`timescale 1ns/10ps
module rac_attach_logic
  import rac_pkg::*;
#(
  parameter int NPOS = RAC_NPOS
) (
  input wire logic ref_clk,
  input wire logic srst,
  rac_link_if.dev link,
  input wire logic cmd_valid,
  input wire rac_cmd_t cmd_code,
  input wire logic [RAC_DW-1:0] cmd_data,
  input wire logic ibus_par_err,
  input wire logic dma_err,
  output logic rsp_valid,
  output logic [RAC_DW-1:0] rsp_data,
  output logic maint_irq,
  output logic ccu_irq,
  output logic l4_irq,
  output logic dma_active,
  output logic [1:0] dma_pos
);
  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {W_IDLE, W_BUILD, W_XFER} rac_wheel_t;
  typedef struct packed {
    rac_wheel_t wheel;
    logic [1:0] ptr, serv;
    logic xerr, connected, masked, disc_pend, reset_ind;
    logic [1:0] l1;
    logic adapter_level1_flag;
    logic [NPOS-1:0] route, withhold;
    logic [3:0] l2;
    logic merr;
    logic [7:0] line_identifier;
    logic [1:0] mm_pos;
    logic [RAC_AW-1:0] mm_addr, acc_addr;
    logic rd_wait, rd_inc;
    logic [NPOS-1:0] grant, bus_err;
    logic mm_req, mm_wr;
    logic [RAC_DW-1:0] mm_wdata;
    logic [1:0] mm_wpar;
    logic rsp_valid;
    logic [RAC_DW-1:0] rsp_data;
    logic maint_irq, ccu_irq, l4_irq, dma_active;
  } rac_dev_state_t;
  rac_dev_state_t st_ff;
  rac_dev_state_t nxt_st;

  // Next requesting position at or after the wheel pointer.
  function automatic logic [2:0] pick(input logic [NPOS-1:0] req, input logic [1:0] from);
    logic [2:0] res;
    logic [1:0] idx;
    res = 3'h0;
    for (int k = NPOS - 1; k >= 0; k--) begin
      idx = 2'(from + 2'(k));
      if (req[idx]) res = {1'b1, idx};
    end
    return res;
  endfunction
  // Type B line identifier of a position.
  function automatic logic [7:0] lid_of(input logic [1:0] pos);
    return 8'(RAC_LID_TYPEB_BASE + {6'h00, pos});
  endfunction
  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  // Clears are applied first and hardware sets last, so an event in the
  // same cycle as its clear survives.
  always_comb begin
    logic [2:0] sel;
    logic [NPOS-1:0] pend;
    logic [NPOS-1:0] direct;
    logic e0, e1;
    sel = 3'h0;
    pend = link.irq_req & ~st_ff.withhold;
    direct = pend & st_ff.route;
    e0 = 1'b0;
    e1 = 1'b0;
    nxt_st = st_ff;
    nxt_st.grant = '0;
    nxt_st.bus_err = '0;
    nxt_st.mm_req = 1'b0;
    nxt_st.rsp_valid = 1'b0;
    // An access carries the pointer as it stood, so a step lands only after it.
    nxt_st.acc_addr = st_ff.mm_addr;
    // Commands; a read in flight holds off further commands.
    if (cmd_valid && !st_ff.rd_wait) begin
      nxt_st.rsp_valid = 1'b1;
      nxt_st.rsp_data = '0;
      case (cmd_code)
        RAC_CMD_CONNECT: begin
          nxt_st.connected = 1'b1;
          nxt_st.l1 = 2'h0;
        end
        RAC_CMD_DISCONNECT: begin
          nxt_st.connected = 1'b0;
          nxt_st.l1[RAC_L1_DISC_BIT] = 1'b1;
          nxt_st.disc_pend = 1'b1;
          nxt_st.adapter_level1_flag = 1'b1;
        end
        RAC_CMD_MASK: nxt_st.masked = 1'b1;
        RAC_CMD_UNMASK: nxt_st.masked = 1'b0;
        RAC_CMD_PROG_RESET: begin
          nxt_st.masked = 1'b0;
          nxt_st.reset_ind = 1'b1;
        end
        RAC_CMD_GCC: begin
          nxt_st.rsp_data[RAC_GCC_DIRECT] = |direct;
          nxt_st.rsp_data[RAC_GCC_MAINT_STAT] = st_ff.merr;
          nxt_st.rsp_data[RAC_GCC_DISC_DONE] = st_ff.disc_pend;
          nxt_st.rsp_data[RAC_GCC_PARITY] = |st_ff.l2[2:0];
          nxt_st.rsp_data[RAC_GCC_MASK_ON] = st_ff.masked;
          nxt_st.rsp_data[RAC_GCC_LID_LSB +: 8] = st_ff.line_identifier;
          nxt_st.merr = 1'b0;
          nxt_st.disc_pend = 1'b0;
        end
        RAC_CMD_GET_L1: begin
          nxt_st.rsp_data[RAC_L1_DISC_BIT] = st_ff.l1[RAC_L1_DISC_BIT];
          nxt_st.rsp_data[RAC_L1_PIOD_BIT] = st_ff.l1[RAC_L1_PIOD_BIT];
          nxt_st.rsp_data[RAC_L1_RESET_BIT] = st_ff.reset_ind;
          nxt_st.adapter_level1_flag = 1'b0;
          nxt_st.reset_ind = 1'b0;
        end
        RAC_CMD_GET_L2: begin
          nxt_st.rsp_data[3:0] = st_ff.l2;
          nxt_st.l2 = 4'h0;
          nxt_st.withhold = '0;
        end
        RAC_CMD_SET_ROUTE: nxt_st.route = cmd_data[NPOS-1:0];
        RAC_CMD_READ_REG: begin
          if (cmd_data[7:0] == RAC_REG_ADAPTER_LEVEL1_FLAG_ADDR) nxt_st.rsp_data[0] = st_ff.adapter_level1_flag;
        end
        RAC_CMD_MM_ADDR: begin
          nxt_st.mm_addr = cmd_data[RAC_AW-1:0];
          nxt_st.mm_pos = cmd_data[9:8];
        end
        RAC_CMD_MM_WRITE, RAC_CMD_MM_WRITE_INC: begin
          nxt_st.mm_req = 1'b1;
          nxt_st.mm_wr = 1'b1;
          nxt_st.mm_wdata = cmd_data;
          nxt_st.mm_wpar = {rac_par(cmd_data[15:8]), rac_par(cmd_data[7:0])};
          if (cmd_code == RAC_CMD_MM_WRITE_INC) begin
            nxt_st.mm_addr = 8'(st_ff.mm_addr + 8'h01);
          end
        end
        RAC_CMD_MM_READ, RAC_CMD_MM_READ_INC: begin
          nxt_st.rsp_valid = 1'b0; // Answered when the data returns.
          nxt_st.mm_req = 1'b1;
          nxt_st.mm_wr = 1'b0;
          nxt_st.rd_wait = 1'b1;
          nxt_st.rd_inc = (cmd_code == RAC_CMD_MM_READ_INC);
        end
        default: nxt_st.rsp_data = '0;
      endcase
    end
    // Read data return with the adapter bus parity checker.
    if (st_ff.rd_wait && link.rd_valid) begin
      nxt_st.rd_wait = 1'b0;
      nxt_st.rsp_valid = 1'b1;
      nxt_st.rsp_data = link.rd_data;
      if (st_ff.rd_inc) nxt_st.mm_addr = 8'(st_ff.mm_addr + 8'h01);
      e0 = link.rd_par[0] != rac_par(link.rd_data[7:0]);
      e1 = link.rd_par[1] != rac_par(link.rd_data[15:8]);
      if (e0 && e1) begin
        nxt_st.l2[RAC_L2_PAR_BOTH] = 1'b1;
      end else if (e0) begin
        nxt_st.l2[RAC_L2_PAR_B0] = 1'b1;
      end else if (e1) begin
        nxt_st.l2[RAC_L2_PAR_B1] = 1'b1;
      end
      if (e0 || e1) nxt_st.line_identifier = lid_of(st_ff.mm_pos);
    end
    // Scan wheel: one grant, one control word build cycle, then the transfer.
    case (st_ff.wheel)
      W_IDLE: begin
        sel = pick(link.bus_req, st_ff.ptr);
        if (sel[2]) begin
          nxt_st.grant[sel[1:0]] = 1'b1;
          nxt_st.serv = sel[1:0];
          nxt_st.xerr = 1'b0;
          nxt_st.wheel = W_BUILD;
        end
      end
      W_BUILD: begin
        if (ibus_par_err) begin
          nxt_st.merr = 1'b1;
          nxt_st.line_identifier = lid_of(st_ff.serv);
        end
        nxt_st.wheel = W_XFER;
      end
      W_XFER: begin
        if (dma_err) nxt_st.xerr = 1'b1;
        if (link.xfer_last) begin
          if (dma_err || st_ff.xerr) begin
            nxt_st.bus_err[st_ff.serv] = 1'b1;
            nxt_st.l2[RAC_L2_DMA_ERR] = 1'b1;
            nxt_st.withhold[st_ff.serv] = 1'b1;
            nxt_st.line_identifier = lid_of(st_ff.serv);
          end
          nxt_st.ptr = 2'(st_ff.serv + 2'h1);
          nxt_st.wheel = W_IDLE;
        end
      end
      default: nxt_st.wheel = W_IDLE;
    endcase
    // Interrupt gating; the mask never blocks the disconnect completion,
    // and once that is serviced while masked only the level 4 line gets through.
    nxt_st.maint_irq = st_ff.disc_pend |
                       (~st_ff.masked & (|direct | st_ff.merr));
    nxt_st.ccu_irq = st_ff.connected & |(pend & ~st_ff.route);
    nxt_st.l4_irq = |st_ff.l2;
    nxt_st.dma_active = (nxt_st.wheel != W_IDLE);
  end
  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  // Out of reset the block is disconnected with programmed I/O disabled.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_ff <= '0;
      st_ff.wheel <= W_IDLE;
      st_ff.l1 <= RAC_L1_RESET_VAL;
    end else begin
      st_ff <= nxt_st;
    end
  end
  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign link.grant = st_ff.grant;
  assign link.bus_err = st_ff.bus_err;
  assign link.mm_req = st_ff.mm_req;
  assign link.mm_wr = st_ff.mm_wr;
  assign link.mm_sel = st_ff.mm_pos;
  assign link.mm_addr = st_ff.acc_addr;
  assign link.mm_wdata = st_ff.mm_wdata;
  assign link.mm_wpar = st_ff.mm_wpar;
  assign rsp_valid = st_ff.rsp_valid;
  assign rsp_data = st_ff.rsp_data;
  assign maint_irq = st_ff.maint_irq;
  assign ccu_irq = st_ff.ccu_irq;
  assign l4_irq = st_ff.l4_irq;
  assign dma_active = st_ff.dma_active;
  assign dma_pos = st_ff.serv;
endmodule // rac_attach_logic

// *** core/rac_ring_adapter.sv ***
// One ring adapter at a fixed position on the adapter bus.
// Assumes the attachment logic shares ref_clk; MEMORY_MAPPED_ACCESS targets it only when
// the position select matches.
`timescale 1ns/10ps
module rac_ring_adapter
  import rac_pkg::*;
#(
  parameter logic [1:0] POS = 2'h0,
  parameter int ST_CYC = RAC_SELFTEST_CYC,
  parameter int LOBE_CYC = RAC_LOBE_CYC
) (
  input wire logic ref_clk,
  input wire logic srst,
  rac_link_if.adp link,
  input wire logic adp_reset,
  input wire logic par_test_opt,
  input wire logic open_wrap,
  input wire logic dma_start,
  input wire logic retry_en,
  input wire logic cb_busy,
  input wire logic irq_ack,
  output logic selftest_done,
  output logic open_done,
  output logic dma_done
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {A_TEST, A_READY, A_REQ, A_XFER, A_CHK, A_LOBE} rac_adp_st_t;

  typedef struct packed {
    rac_adp_st_t st;
    logic [7:0] cnt;
    logic [7:0][RAC_DW-1:0] mem;
    logic par_opt;
    logic cb_req;
    logic irq;
    logic req;
    logic xfer_last;
    logic rd_valid;
    logic [RAC_DW-1:0] rd_data;
    logic [1:0] rd_par;
    logic selftest_done;
    logic open_done;
    logic dma_done;
  } rac_adp_state_t;

  rac_adp_state_t st_ff;
  rac_adp_state_t nxt_st;

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.xfer_last = 1'b0;
    nxt_st.rd_valid = 1'b0;
    nxt_st.dma_done = 1'b0;
    nxt_st.open_done = 1'b0;
    if (irq_ack) begin
      nxt_st.irq = 1'b0;
    end

    // Register access; parity is forced low under the parity test option.
    if (link.mm_req && link.mm_sel == POS) begin
      if (link.mm_wr) begin
        nxt_st.mem[link.mm_addr[2:0]] = link.mm_wdata;
        if (link.mm_addr[2:0] == RAC_IRQREG_IDX) begin
          nxt_st.cb_req = link.mm_wdata[0];
        end
      end else begin
        nxt_st.rd_valid = 1'b1;
        nxt_st.rd_data = st_ff.mem[link.mm_addr[2:0]];
        nxt_st.rd_par = st_ff.par_opt ? 2'h0 :
          {rac_par(st_ff.mem[link.mm_addr[2:0]][15:8]),
           rac_par(st_ff.mem[link.mm_addr[2:0]][7:0])};
      end
    end

    // Command block request: interrupt once the block is free again.
    if (st_ff.cb_req && !cb_busy) begin
      nxt_st.cb_req = 1'b0;
      nxt_st.irq = 1'b1;
    end

    case (st_ff.st)
      A_TEST: begin
        if (st_ff.cnt == 8'(ST_CYC - 1)) begin
          nxt_st.mem[RAC_SELFTEST_IDX] = RAC_SELFTEST_PASS;
          nxt_st.selftest_done = 1'b1;
          nxt_st.st = A_READY;
        end else begin
          nxt_st.cnt = 8'(st_ff.cnt + 8'h01);
        end
      end
      A_READY: begin
        if (open_wrap) begin
          nxt_st.cnt = 8'h00;
          nxt_st.st = A_LOBE;
        end else if (dma_start) begin
          nxt_st.req = 1'b1;
          nxt_st.st = A_REQ;
        end
      end
      A_REQ: begin
        if (link.grant[POS]) begin
          nxt_st.req = 1'b0;
          nxt_st.xfer_last = 1'b1;
          nxt_st.st = A_XFER;
        end
      end
      A_XFER: nxt_st.st = A_CHK;
      A_CHK: begin
        if (link.bus_err[POS] && retry_en) begin
          nxt_st.req = 1'b1;
          nxt_st.st = A_REQ;
        end else begin
          nxt_st.dma_done = 1'b1;
          nxt_st.st = A_READY;
        end
      end
      A_LOBE: begin
        // Wrap open runs only the lobe test and posts its status.
        if (st_ff.cnt == 8'(LOBE_CYC - 1)) begin
          nxt_st.mem[RAC_SSB_IDX] = RAC_LOBE_PASS;
          nxt_st.open_done = 1'b1;
          nxt_st.irq = 1'b1;
          nxt_st.st = A_READY;
        end else begin
          nxt_st.cnt = 8'(st_ff.cnt + 8'h01);
        end
      end
      default: nxt_st.st = A_READY;
    endcase

    // A reset restarts the self test and catches the parity test option.
    if (adp_reset) begin
      nxt_st = '0;
      nxt_st.st = A_TEST;
      nxt_st.par_opt = par_test_opt;
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_ff <= '0;
      st_ff.st <= A_TEST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign link.bus_req = st_ff.req ? (RAC_NPOS'(1) << POS) : '0;
  assign link.irq_req = st_ff.irq ? (RAC_NPOS'(1) << POS) : '0;
  assign link.xfer_last = st_ff.xfer_last;
  assign link.rd_valid = st_ff.rd_valid;
  assign link.rd_data = st_ff.rd_data;
  assign link.rd_par = st_ff.rd_par;
  assign selftest_done = st_ff.selftest_done;
  assign open_done = st_ff.open_done;
  assign dma_done = st_ff.dma_done;

endmodule // rac_ring_adapter

// *** tb/rac_link_properties.sv ***
// Concurrent checks on the adapter bus between the two ends.
// Assumes the bench wires the interface signals in and holds srst high at start.
`timescale 1ns/10ps
module rac_link_properties
  import rac_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [RAC_NPOS-1:0] grant,
  input wire logic [RAC_NPOS-1:0] bus_err,
  input wire logic mm_req,
  input wire logic mm_wr,
  input wire logic [RAC_DW-1:0] mm_wdata,
  input wire logic [1:0] mm_wpar,
  input wire logic [RAC_NPOS-1:0] bus_req,
  input wire logic xfer_last,
  input wire logic rd_valid
);
  // ----------------------------------------
  // Bus checks
  // ----------------------------------------
  // Only position 0 is populated, so only its request bit is trusted.
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  chk_grant_onehot: assert property ($onehot0(grant))
    else $error("grant not one-hot");
  chk_grant_pulse: assert property (grant != '0 |=> grant == '0)
    else $error("grant longer than one cycle");
  chk_grant_cause: assert property (grant[0] |-> $past(bus_req[0]))
    else $error("grant without request");
  chk_xfer_follow: assert property (grant[0] |-> ##[1:3] xfer_last)
    else $error("no transfer end after grant");
  chk_transfer_error_tag_cause: assert property (bus_err != '0 |-> $past(xfer_last))
    else $error("bus error outside transfer end");
  chk_read_pulse: assert property (mm_req && !mm_wr |=> !mm_req)
    else $error("access issued while a read waits");
  chk_wpar_odd: assert property (mm_req && mm_wr |->
    mm_wpar == {~^mm_wdata[15:8], ~^mm_wdata[7:0]})
    else $error("write parity wrong");
  chk_read_answer: assert property (mm_req && !mm_wr |=> rd_valid)
    else $error("read not answered");
endmodule // rac_link_properties

// *** tb/ring_adapter_attach_ctrl_bench.sv ***
// Self-checking bench joining the attachment logic to one adapter.
// Assumes the adapter sits at position 0 and shortened test counts are legal.
`timescale 1ns/10ps
module ring_adapter_attach_ctrl_bench;
  import rac_pkg::*;
  logic ref_clk = 0, srst = 1, cmd_valid = 0, ibus_par_err = 0, dma_err = 0;
  logic adp_reset = 0, par_test_opt = 0, open_wrap = 0, dma_start = 0;
  logic retry_en = 0, cb_busy = 0, irq_ack = 0;
  logic rsp_valid, maint_irq, ccu_irq, l4_irq, dma_active, st_done;
  logic [1:0] dpos;
  logic [15:0] cmd_data = '0, rsp_data, rsp;
  logic [15:0] pv [3] = '{16'h0100, 16'h0001, 16'h0000};
  rac_cmd_t cmd_code = RAC_CMD_GCC;
  int n_errors = 0, total_checks = 0, cyc = 0, i;
  always #20 ref_clk = ~ref_clk;
  rac_link_if link();
  rac_attach_logic i_rac_attach_logic(.ref_clk, .srst, .link(link.dev), .cmd_valid,
    .cmd_code, .cmd_data, .ibus_par_err, .dma_err, .rsp_valid, .rsp_data, .maint_irq,
    .ccu_irq, .l4_irq, .dma_active, .dma_pos(dpos));
  rac_ring_adapter #(.POS(2'h0), .ST_CYC(4), .LOBE_CYC(4)) i_rac_ring_adapter(.ref_clk,
    .srst, .link(link.adp), .adp_reset, .par_test_opt, .open_wrap, .dma_start, .retry_en,
    .cb_busy, .irq_ack, .selftest_done(st_done), .open_done(), .dma_done());
  rac_link_properties i_rac_link_properties(.ref_clk, .srst, .grant(link.grant),
    .bus_err(link.bus_err), .mm_req(link.mm_req), .mm_wr(link.mm_wr),
    .mm_wdata(link.mm_wdata), .mm_wpar(link.mm_wpar), .bus_req(link.bus_req),
    .xfer_last(link.xfer_last), .rd_valid(link.rd_valid));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Issues one command and waits, bounded, for its answer.
  task automatic cmd(input rac_cmd_t c, input logic [15:0] d);
    int k;
    @(negedge ref_clk);
    cmd_code = c;
    cmd_data = d;
    cmd_valid = 1;
    for (k = 0; k < 8; k++) begin
      @(negedge ref_clk);
      cmd_valid = 0;
      if (rsp_valid === 1'b1) break;
    end
    rsp = rsp_data;
  endtask
  task automatic waitc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic complete_run;
    if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // A hang counts as a mismatch; the full run needs well under 2000 cycles.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      complete_run;
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    waitc(16);
    srst = 0;
    for (i = 0; i < 100 && st_done !== 1'b1; i++) waitc(1);
    cmd(RAC_CMD_GET_L1, '0);
    chk(rsp & 16'h0003, 16'h0003);
    cmd(RAC_CMD_MM_ADDR, 16'h0000);
    cmd(RAC_CMD_MM_READ, '0);
    chk(rsp, RAC_SELFTEST_PASS);
    // Two stepping writes from word 3, then a stepping read and a plain one behind it.
    cmd(RAC_CMD_MM_ADDR, 16'h0003);
    cmd(RAC_CMD_MM_WRITE_INC, 16'hA5A5);
    cmd(RAC_CMD_MM_WRITE_INC, 16'h5A5A);
    cmd(RAC_CMD_MM_ADDR, 16'h0003);
    cmd(RAC_CMD_MM_READ_INC, '0);
    chk(rsp, 16'hA5A5);
    cmd(RAC_CMD_MM_READ, '0);
    chk(rsp, 16'h5A5A);
    cmd(RAC_CMD_SET_ROUTE, 16'h000F);
    cmd(RAC_CMD_CONNECT, '0);
    cmd(RAC_CMD_GET_L1, '0);
    chk(rsp & 16'h0003, 16'h0000);
    cmd(RAC_CMD_MM_ADDR, 16'h0001);
    cmd(RAC_CMD_MM_WRITE, 16'h0001);
    waitc(4);
    chk({15'h0, maint_irq}, 16'h0001);
    chk({15'h0, ccu_irq}, 16'h0000);
    // With no routing bit the same request goes to the control unit instead.
    cmd(RAC_CMD_SET_ROUTE, 16'h0000);
    waitc(2);
    chk({15'h0, ccu_irq}, 16'h0001);
    chk({15'h0, maint_irq}, 16'h0000);
    cmd(RAC_CMD_SET_ROUTE, 16'h000F);
    cmd(RAC_CMD_MASK, '0);
    waitc(3);
    chk({15'h0, maint_irq}, 16'h0000);
    cmd(RAC_CMD_DISCONNECT, '0);
    waitc(3);
    chk({15'h0, maint_irq}, 16'h0001);
    cmd(RAC_CMD_READ_REG, 16'h007E);
    chk(rsp & 16'h0001, 16'h0001);
    cmd(RAC_CMD_GCC, '0);
    chk(rsp & 16'h0014, 16'h0014);
    waitc(3);
    chk({15'h0, maint_irq}, 16'h0000);
    cmd(RAC_CMD_GET_L1, '0);
    cmd(RAC_CMD_READ_REG, 16'h007E);
    chk(rsp & 16'h0001, 16'h0000);
    cmd(RAC_CMD_UNMASK, '0);
    waitc(3);
    chk({15'h0, maint_irq}, 16'h0001);
    cmd(RAC_CMD_MASK, '0);
    cmd(RAC_CMD_PROG_RESET, '0);
    waitc(3);
    chk({15'h0, maint_irq}, 16'h0001);
    cmd(RAC_CMD_GET_L1, '0);
    chk(rsp & 16'h0004, 16'h0004);
    irq_ack = 1;
    waitc(1);
    irq_ack = 0;
    // Both faults are held through the whole transfer; the device samples them itself.
    ibus_par_err = 1;
    dma_err = 1;
    dma_start = 1;
    waitc(1);
    dma_start = 0;
    waitc(1);
    chk({13'h0, dma_active, dpos}, 16'h0004);
    waitc(11);
    ibus_par_err = 0;
    dma_err = 0;
    cmd(RAC_CMD_GCC, '0);
    chk(rsp & 16'hFF02, 16'h2002);
    // The failed position's new request stays held back until level 2 is read.
    cmd(RAC_CMD_MM_ADDR, 16'h0001);
    cmd(RAC_CMD_MM_WRITE, 16'h0001);
    waitc(4);
    chk({15'h0, maint_irq}, 16'h0000);
    cmd(RAC_CMD_GET_L2, '0);
    chk(rsp & 16'h0008, 16'h0008);
    waitc(3);
    chk({15'h0, maint_irq}, 16'h0001);
    // A wrap open runs the short lobe test and posts its status word.
    open_wrap = 1;
    waitc(1);
    open_wrap = 0;
    waitc(8);
    cmd(RAC_CMD_MM_ADDR, 16'h0002);
    cmd(RAC_CMD_MM_READ, '0);
    chk(rsp, RAC_LOBE_PASS);
    par_test_opt = 1;
    adp_reset = 1;
    waitc(1);
    adp_reset = 0;
    waitc(12);
    for (i = 0; i < 3; i++) begin
      cmd(RAC_CMD_MM_ADDR, 16'h0002);
      cmd(RAC_CMD_MM_WRITE, pv[i]);
      cmd(RAC_CMD_MM_READ, '0);
      // The level 4 line follows the logged error by one cycle.
      waitc(1);
      chk({15'h0, l4_irq}, 16'h0001);
      cmd(RAC_CMD_GCC, '0);
      chk(rsp & 16'hFF08, 16'h2008);
      cmd(RAC_CMD_GET_L2, '0);
      chk(rsp & 16'h0007, 16'h0001 << i);
    end
    complete_run;
  end
endmodule // ring_adapter_attach_ctrl_bench
